// *** test/dbl_dev_model.sv ***
/*
 file: behavioural model of one double-buffered 12-bit converter latch.
 assumes: nibble data is already routed to the three input latches; the
 host clock samples the pins, so a latch is open for whole cycles.
*/
`timescale 1ns/1ps
module dbl_dev_model (
   input wire logic clock,
   input wire logic wr_n,
   input wire logic hi_n,
   input wire logic mid_n,
   input wire logic lo_n,
   input wire logic ld_n,
   input wire logic [3:0] hi_d,
   input wire logic [3:0] mid_d,
   input wire logic [3:0] lo_d,
   output logic [11:0] out_q
);
   logic [11:0] in_q;
   logic [11:0] in_d;
   // open input latch passes straight on to the converter rank
   assign in_d[11:8] = (!hi_n && !wr_n) ? hi_d : in_q[11:8];
   assign in_d[7:4] = (!mid_n && !wr_n) ? mid_d : in_q[7:4];
   assign in_d[3:0] = (!lo_n && !wr_n) ? lo_d : in_q[3:0];
   always_ff @(posedge clock) begin
      in_q <= in_d;
   end
   always_ff @(posedge clock) begin
      if (!ld_n && !wr_n) out_q <= in_d;
   end
endmodule : dbl_dev_model

// *** test/dbl_host_chk.sv ***
/*
 file: pin-level checker for the converter host controller.
 assumes: bound into dbl_host; sees only its ports.
*/
`timescale 1ns/1ps
module dbl_host_chk
   import dbl_pkg::*;
#(
   parameter int unsigned N_DEV = 2,
   parameter int unsigned WR_CYC = DBL_WR_CYC
)
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic req_ready,
   input wire logic done,
   input wire logic wr_n,
   input wire logic [N_DEV-1:0] nib_hi_en_n,
   input wire logic [N_DEV-1:0] nib_mid_en_n,
   input wire logic [N_DEV-1:0] nib_lo_en_n,
   input wire logic [N_DEV-1:0] converter_load_enable_n,
   input wire logic [DBL_BUS_W-1:0] code_input_pins
);
   logic [4*N_DEV-1:0] en_all;
   logic [7:0] low_q;
   assign en_all = {converter_load_enable_n, nib_lo_en_n, nib_mid_en_n,
      nib_hi_en_n};
   // strobe-low cycles seen so far
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) low_q <= 8'h00;
      else if (!wr_n) low_q <= low_q + 8'h01;
      else low_q <= 8'h00;
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   chk_strobe_width: assert property (
      $rose(wr_n) |-> low_q == WR_CYC) else $error("strobe width off");
   chk_strobe_bound: assert property (
      !wr_n |-> low_q < WR_CYC) else $error("strobe too long");
   chk_en_steady: assert property (
      !wr_n |-> $stable(en_all) && $stable(code_input_pins))
      else $error("pins moved under strobe");
   chk_en_hold: assert property (
      $rose(wr_n) |-> $stable(en_all) && $stable(code_input_pins))
      else $error("pins moved at strobe release");
   chk_some_latch: assert property (
      !wr_n |-> !(&en_all)) else $error("strobe with no latch");
   chk_idle_quiet: assert property (
      req_ready |-> wr_n && (&en_all)) else $error("idle not quiet");
   chk_busy_quiet: assert property (
      !wr_n |-> !req_ready && !done) else $error("ready under strobe");
   chk_done_after: assert property (
      done |-> wr_n && !$past(wr_n))
      else $error("done not with strobe release");
   chk_done_pulse: assert property (
      done |=> !done) else $error("done longer than one cycle");
   cover property (!wr_n && converter_load_enable_n == '0);
   cover property (!wr_n && !nib_hi_en_n[0] && !converter_load_enable_n[0]);
   cover property (done);
endmodule : dbl_host_chk

bind dbl_host dbl_host_chk #(.N_DEV(N_DEV), .WR_CYC(WR_CYC)) i_chk (
   .clock(clock), .sys_rst(sys_rst), .req_ready(req_ready), .done(done),
   .wr_n(wr_n), .nib_hi_en_n(nib_hi_en_n), .nib_mid_en_n(nib_mid_en_n),
   .nib_lo_en_n(nib_lo_en_n),
   .converter_load_enable_n(converter_load_enable_n),
   .code_input_pins(code_input_pins));

// *** test/dbl_host_test.sv ***
/*
 file: self-checking bench for the converter host with two device models.
 assumes: dbl_pkg, dbl_host and dbl_dev_model compiled before it.
*/
`timescale 1ns/1ps
module dbl_host_test;
   import dbl_pkg::*;
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic req_valid = 1'b0;
   logic [2:0] flags = 3'h0;
   logic [1:0] req_mode = 2'h0;
   logic [1:0] req_sel = 2'h0;
   logic [11:0] req_code = 12'h000;
   logic req_ready, done, wr_n;
   logic [1:0] hi_n, mid_n, lo_n, ld_n;
   logic [15:0] pins;
   logic [3:0] hi_d, mid_d, lo_d;
   logic [11:0] out0, out1;
   int failures = 0;
   int compares = 0;
   always #10 clock = ~clock;
   dbl_host i_dut (.clock(clock), .sys_rst(sys_rst), .req_valid(req_valid),
      .req_mode(req_mode), .req_code(req_code), .req_sel(req_sel),
      .req_twos(flags[2]), .req_defer(flags[1]), .req_update(flags[0]),
      .req_ready(req_ready), .done(done), .wr_n(wr_n), .nib_hi_en_n(hi_n),
      .nib_mid_en_n(mid_n), .nib_lo_en_n(lo_n),
      .converter_load_enable_n(ld_n), .code_input_pins(pins));
   // board wiring of the device data pins for each bus width
   always_comb begin
      case (req_mode)
         2'h0: {hi_d, mid_d, lo_d} = {3{pins[3:0]}};
         2'h1: {hi_d, mid_d, lo_d} = {pins[3:0], pins[7:0]};
         2'h2: {hi_d, mid_d, lo_d} = {pins[7:0], pins[7:4]};
         default: {hi_d, mid_d, lo_d} = pins[11:0];
      endcase
   end
   dbl_dev_model i_dev0 (.clock(clock), .wr_n(wr_n), .hi_n(hi_n[0]),
      .mid_n(mid_n[0]), .lo_n(lo_n[0]), .ld_n(ld_n[0]), .hi_d(hi_d),
      .mid_d(mid_d), .lo_d(lo_d), .out_q(out0));
   dbl_dev_model i_dev1 (.clock(clock), .wr_n(wr_n), .hi_n(hi_n[1]),
      .mid_n(mid_n[1]), .lo_n(lo_n[1]), .ld_n(ld_n[1]), .hi_d(hi_d),
      .mid_d(mid_d), .lo_d(lo_d), .out_q(out1));
   task automatic conclude();
      if (failures == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : conclude
   task automatic hang();
      failures++;
      conclude();
   endtask : hang
   task automatic check(input logic [11:0] seen, input logic [11:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // one request, f = {twos, defer, update}
   task automatic send(input logic [1:0] m, input logic [11:0] c,
         input logic [1:0] s, input logic [2:0] f);
      int n;
      n = 0;
      while (req_ready !== 1'b1) begin
         n++;
         if (n > 50) hang();
         @(posedge clock);
         #1;
      end
      req_mode = m;
      req_code = c;
      req_sel = s;
      flags = f;
      req_valid = 1'b1;
      @(posedge clock);
      #1;
      req_valid = 1'b0;
      n = 0;
      while (done !== 1'b1) begin
         n++;
         if (n > 200) hang();
         @(posedge clock);
         #1;
      end
   endtask : send
   task automatic t_full();
      send(2'h3, 12'ha5c, 2'h3, 3'h0);
      check(out0, 12'ha5c);
      check(out1, 12'ha5c);
   endtask : t_full
   task automatic t_nibble();
      send(2'h0, 12'h3e7, 2'h2, 3'h0);
      check(out1, 12'h3e7);
      check(out0, 12'ha5c);
   endtask : t_nibble
   task automatic t_right();
      send(2'h1, 12'h81f, 2'h1, 3'h0);
      check(out0, 12'h81f);
      check(out1, 12'h3e7);
   endtask : t_right
   task automatic t_left();
      send(2'h2, 12'h6b2, 2'h2, 3'h0);
      check(out1, 12'h6b2);
   endtask : t_left
   task automatic t_twos();
      send(2'h3, 12'h123, 2'h1, 3'h4);
      check(out0, 12'h923);
   endtask : t_twos
   task automatic t_common();
      send(2'h0, 12'h456, 2'h3, 3'h2);
      check(out0, 12'h923);
      check(out1, 12'h6b2);
      send(2'h0, 12'h000, 2'h3, 3'h1);
      check(out0, 12'h456);
      check(out1, 12'h456);
   endtask : t_common
   initial begin
      repeat (16) @(posedge clock);
      #1;
      sys_rst = 1'b0;
      t_full();
      t_nibble();
      t_right();
      t_left();
      t_twos();
      t_common();
      conclude();
   end
endmodule : dbl_host_test

// *** verilog/dbl_host.sv ***
/*
 file: host controller that writes 12-bit codes into a double-buffered
 converter through its write strobe, latch enables and data pins.
 assumes: device pins are wired straight to the outputs; the device
 needs no clock; requests come from logic on the same clock.
*/
// Function
// - several enables may open in one write
// - host drives one shared strobe; select gates only the enables
// - multi-device update uses one common load
// - 4-bit bus uses four addresses per device
// - 8-bit bus uses two adjacent byte writes
// - right-justified: low byte, then high plus load
// - unused address pairings never issued
// - twos complement by inverting code msb
`timescale 1ns/1ps
module dbl_host
   import dbl_pkg::*;
#(
   parameter int unsigned N_DEV = 2,
   parameter int unsigned WR_CYC = DBL_WR_CYC,
   parameter int unsigned SU_CYC = DBL_SU_CYC
)
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic req_valid,
   input wire logic [1:0] req_mode,
   input wire logic [DBL_CODE_W-1:0] req_code,
   input wire logic [N_DEV-1:0] req_sel,
   input wire logic req_twos,
   input wire logic req_defer,
   input wire logic req_update,
   output logic req_ready,
   output logic done,
   output logic wr_n,
   output logic [N_DEV-1:0] nib_hi_en_n,
   output logic [N_DEV-1:0] nib_mid_en_n,
   output logic [N_DEV-1:0] nib_lo_en_n,
   output logic [N_DEV-1:0] converter_load_enable_n,
   output logic [DBL_BUS_W-1:0] code_input_pins
);
   dbl_state_t state_q;
   dbl_mode_t mode_q;
   logic [DBL_CODE_W-1:0] code_q;
   logic [N_DEV-1:0] sel_q;
   logic [1:0] step_q;
   logic load_q;
   logic upd_q;
   logic [DBL_CNT_W-1:0] cnt_q;
   logic [3:0] step_en_n;
   logic wr_d;
   logic cnt_done;
   dbl_step_if st ();

   dbl_step_plan u_plan (
      .mode(mode_q),
      .code(code_q),
      .step(step_q),
      .with_load(load_q),
      .st(st)
   );

   assign cnt_done = (cnt_q == '0);
   // global update is one strobe on load only
   assign step_en_n = upd_q ? {1'b0, 3'h7} : st.en_n;

   // request capture
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         mode_q <= DBL_MODE_4;
         code_q <= '0;
         sel_q <= '0;
         load_q <= 1'b0;
         upd_q <= 1'b0;
      end else if (state_q == DBL_ST_IDLE && req_valid) begin
         mode_q <= dbl_mode_t'(req_mode);
         // msb inverted for twos complement input
         code_q <= {req_code[DBL_CODE_W-1] ^ req_twos,
            req_code[DBL_CODE_W-2:0]};
         sel_q <= req_sel;
         load_q <= !req_defer;
         upd_q <= req_update;
      end
   end

   // sequencer: setup, strobe low, hold, next step
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         state_q <= DBL_ST_IDLE;
         step_q <= 2'h0;
         cnt_q <= '0;
      end else begin
         unique case (state_q)
            DBL_ST_IDLE: begin
               step_q <= 2'h0;
               if (req_valid) begin
                  state_q <= DBL_ST_SETUP;
                  cnt_q <= DBL_CNT_W'(SU_CYC - 1);
               end
            end
            DBL_ST_SETUP: begin
               if (cnt_done) begin
                  state_q <= DBL_ST_STROBE;
                  cnt_q <= DBL_CNT_W'(WR_CYC - 1);
               end else begin
                  cnt_q <= cnt_q - 1'b1;
               end
            end
            DBL_ST_STROBE: begin
               if (cnt_done) begin
                  state_q <= DBL_ST_HOLD;
               end else begin
                  cnt_q <= cnt_q - 1'b1;
               end
            end
            DBL_ST_HOLD: begin
               // strobe is still low here; it rises at the next edge with enables still held
               state_q <= (st.last || upd_q) ? DBL_ST_IDLE : DBL_ST_NEXT;
            end
            DBL_ST_NEXT: begin
               // next address of the same device
               step_q <= step_q + 2'h1;
               state_q <= DBL_ST_SETUP;
               cnt_q <= DBL_CNT_W'(SU_CYC - 1);
            end
         endcase
      end
   end

   assign wr_d = (state_q != DBL_ST_STROBE);

   // strobe shared by all devices, not gated by device selection
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         wr_n <= 1'b1;
      end else begin
         wr_n <= wr_d;
      end
   end

   // per-device enables; unselected devices stay closed
   genvar g;
   for (g = 0; g < N_DEV; g++) begin : g_dev
      always_ff @(posedge clock or posedge sys_rst) begin
         if (sys_rst) begin
            nib_hi_en_n[g] <= 1'b1;
            nib_mid_en_n[g] <= 1'b1;
            nib_lo_en_n[g] <= 1'b1;
            converter_load_enable_n[g] <= 1'b1;
         end else if (state_q == DBL_ST_SETUP ||
               state_q == DBL_ST_STROBE) begin
            // several enables together in one write
            nib_hi_en_n[g] <= step_en_n[DBL_EN_HI] | ~sel_q[g];
            nib_mid_en_n[g] <= step_en_n[DBL_EN_MID] | ~sel_q[g];
            nib_lo_en_n[g] <= step_en_n[DBL_EN_LO] | ~sel_q[g];
            converter_load_enable_n[g] <=
               step_en_n[DBL_EN_LD] | ~sel_q[g];
         end else if (state_q != DBL_ST_HOLD) begin
            nib_hi_en_n[g] <= DBL_EN_NONE[DBL_EN_HI];
            nib_mid_en_n[g] <= DBL_EN_NONE[DBL_EN_MID];
            nib_lo_en_n[g] <= DBL_EN_NONE[DBL_EN_LO];
            converter_load_enable_n[g] <= DBL_EN_NONE[DBL_EN_LD];
         end
      end
   end

   // data held through hold so the latch closes on stable data
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         code_input_pins <= '0;
      end else if (state_q == DBL_ST_SETUP) begin
         code_input_pins <= st.data;
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         req_ready <= 1'b0;
         done <= 1'b0;
      end else begin
         req_ready <= (state_q == DBL_ST_IDLE) && !req_valid;
         done <= (state_q == DBL_ST_HOLD) && (st.last || upd_q);
      end
   end
endmodule : dbl_host

// *** verilog/dbl_pkg.sv ***
/*
 file: constants for the host controller driving a double-buffered
 12-bit converter input latch through its pins.
 assumes: a 50 MHz system clock; the device pins are plain wires.
*/
package dbl_pkg;
   localparam int unsigned DBL_CODE_W = 12;
   localparam int unsigned DBL_NIB_W = 4;
   localparam int unsigned DBL_NIB_N = 3;
   localparam int unsigned DBL_BUS_W = 16;
   localparam int unsigned DBL_CLK_MHZ = 50;
   // least strobe-low time and least setup, in ns
   localparam int unsigned DBL_T_WR_NS = 100;
   localparam int unsigned DBL_T_SU_NS = 40;
   localparam int unsigned DBL_WR_CYC =
      (DBL_T_WR_NS * DBL_CLK_MHZ + 999) / 1000;
   localparam int unsigned DBL_SU_CYC =
      (DBL_T_SU_NS * DBL_CLK_MHZ + 999) / 1000;
   localparam int unsigned DBL_CNT_W = 8;
   // nibble positions inside the 12-bit code
   localparam int unsigned DBL_MSB_LO = 8;
   localparam int unsigned DBL_MID_LO = 4;
   localparam int unsigned DBL_LSB_LO = 0;
   // enable vector bit order: {load, low, middle, high}
   localparam int unsigned DBL_EN_HI = 0;
   localparam int unsigned DBL_EN_MID = 1;
   localparam int unsigned DBL_EN_LO = 2;
   localparam int unsigned DBL_EN_LD = 3;
   localparam logic [3:0] DBL_EN_NONE = 4'hf;

   // bus modes: how one request is split into strobes
   typedef enum logic [1:0] {
      DBL_MODE_4 = 2'h0,
      DBL_MODE_8R = 2'h1,
      DBL_MODE_8L = 2'h2,
      DBL_MODE_12 = 2'h3
   } dbl_mode_t;

   typedef enum logic [4:0] {
      DBL_ST_IDLE = 5'h01,
      DBL_ST_SETUP = 5'h02,
      DBL_ST_STROBE = 5'h04,
      DBL_ST_HOLD = 5'h08,
      DBL_ST_NEXT = 5'h10
   } dbl_state_t;
endpackage : dbl_pkg

// *** verilog/dbl_step_if.sv ***
/*
 file: interface carrying one write step between the step planner and
 the pin sequencer.
 assumes: one clock domain.
*/
`timescale 1ns/1ps
interface dbl_step_if;
   import dbl_pkg::*;
   logic [DBL_BUS_W-1:0] data;
   logic [3:0] en_n;
   logic last;
   modport planner (output data, output en_n, output last);
   modport sequencer (input data, input en_n, input last);
endinterface : dbl_step_if

// *** verilog/dbl_step_plan.sv ***
/*
 file: combinational planner: for a bus mode, code and step index it
 gives the data word and latch enables of that write step.
 assumes: the caller holds mode, code and step stable across a step.
*/
`timescale 1ns/1ps
module dbl_step_plan
   import dbl_pkg::*;
(
   input wire dbl_mode_t mode,
   input wire logic [DBL_CODE_W-1:0] code,
   input wire logic [1:0] step,
   input wire logic with_load,
   dbl_step_if.planner st
);
   logic [3:0] en;

   always_comb begin
      en = 4'h0;
      st.data = '0;
      st.last = 1'b1;
      unique case (mode)
         DBL_MODE_4: begin
            // one nibble per address, then a separate load
            st.last = (step == 2'h3) || (!with_load && step == 2'h2);
            en[step] = 1'b1;
            unique case (step)
               2'h0: st.data[DBL_NIB_W-1:0] =
                  code[DBL_MSB_LO +: DBL_NIB_W];
               2'h1: st.data[DBL_NIB_W-1:0] =
                  code[DBL_MID_LO +: DBL_NIB_W];
               2'h2: st.data[DBL_NIB_W-1:0] =
                  code[DBL_LSB_LO +: DBL_NIB_W];
               default: st.data = '0;
            endcase
         end
         DBL_MODE_8R: begin
            // low byte first, then high nibble with the load
            // only these two pairings are ever issued
            st.last = (step != 2'h0);
            if (step == 2'h0) begin
               en[DBL_EN_MID] = 1'b1;
               en[DBL_EN_LO] = 1'b1;
               st.data[2*DBL_NIB_W-1:0] = code[DBL_LSB_LO +: 2*DBL_NIB_W];
            end else begin
               en[DBL_EN_HI] = 1'b1;
               en[DBL_EN_LD] = with_load;
               st.data[DBL_NIB_W-1:0] = code[DBL_MSB_LO +: DBL_NIB_W];
            end
         end
         DBL_MODE_8L: begin
            // high byte first, then low nibble with the load
            st.last = (step != 2'h0);
            if (step == 2'h0) begin
               en[DBL_EN_HI] = 1'b1;
               en[DBL_EN_MID] = 1'b1;
               st.data[2*DBL_NIB_W-1:0] = code[DBL_MID_LO +: 2*DBL_NIB_W];
            end else begin
               en[DBL_EN_LO] = 1'b1;
               en[DBL_EN_LD] = with_load;
               st.data[DBL_NIB_W +: DBL_NIB_W] =
                  code[DBL_LSB_LO +: DBL_NIB_W];
            end
         end
         DBL_MODE_12: begin
            // all three input latches, and load unless deferred, open at once in one write
            en = {with_load, 3'h7};
            st.data[DBL_CODE_W-1:0] = code;
         end
      endcase
      st.en_n = ~en;
   end
endmodule : dbl_step_plan
